// file: verilog/pwmusc_top.sv
// Purpose: Update and synchronisation control of a motor-control PWM unit.
// Assumes: Time-base update point and special events are one-cycle pulses on CORE_CLK.
// Notes:   APB slave with one wait state; all outputs come from flip-flops.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module pwmusc_top
	import pwmusc_pkg::*;
(
	// Clock and reset.
	input  wire logic                          CORE_CLK,
	input  wire logic                          RSTN,
	// APB slave.
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [pwmusc_pkg::ADDR_W-1:0] PADDR,
	input  wire logic [pwmusc_pkg::DATA_W-1:0] PWDATA,
	output logic      [pwmusc_pkg::DATA_W-1:0] PRDATA,
	output logic                               PREADY,
	output logic                               PSLVERR,
	// Time base and trigger events.
	input  wire logic                          TIME_BASE_SYNC,
	input  wire logic                          SPECIAL_EVENT,
	output logic                               SPECIAL_TRIGGER,
	// Active values for the comparators and override logic.
	output logic      [pwmusc_pkg::VAL_W-1:0]  ACTIVE_DUTY,
	output logic      [pwmusc_pkg::VAL_W-1:0]  ACTIVE_PERIOD,
	output logic      [pwmusc_pkg::VAL_W-1:0]  ACTIVE_OVERRIDE
);
	import pwmusc_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [POST_W-1:0] event_trigger_postscale_select;
	logic              immediate_update;
	logic              override_time_base_sync;
	logic              buffer_transfer_disable;
	logic [VAL_W-1:0]  duty_cycle_register;
	logic [VAL_W-1:0]  period_buffer;
	logic [VAL_W-1:0]  output_override_control;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	pwmusc_sel_t sel;

	// Address decode; anything off the map selects nothing and errors.
	always_comb begin
		if (PADDR == ADDR_CONTROL) begin
			sel = PWMUSC_SEL_CTRL;
		end else if (PADDR == ADDR_DUTY) begin
			sel = PWMUSC_SEL_DUTY;
		end else if (PADDR == ADDR_PERIOD) begin
			sel = PWMUSC_SEL_PER;
		end else if (PADDR == ADDR_OVERRIDE) begin
			sel = PWMUSC_SEL_OVR;
		end else if (PADDR == ADDR_ACT_DUTY) begin
			sel = PWMUSC_SEL_ADUTY;
		end else if (PADDR == ADDR_ACT_PERIOD) begin
			sel = PWMUSC_SEL_APER;
		end else if (PADDR == ADDR_ACT_OVR) begin
			sel = PWMUSC_SEL_AOVR;
		end else begin
			sel = PWMUSC_SEL_NONE;
		end
	end

	// The access completes on the edge where PREADY is seen high.
	wire access    = PSEL && PENABLE;
	wire complete  = access && PREADY;
	wire wr_ok     = complete && PWRITE;
	wire wr_ctrl   = wr_ok && (sel == PWMUSC_SEL_CTRL);
	wire wr_duty   = wr_ok && (sel == PWMUSC_SEL_DUTY);
	wire wr_period = wr_ok && (sel == PWMUSC_SEL_PER);
	wire wr_ovr    = wr_ok && (sel == PWMUSC_SEL_OVR);

	// Active registers are read-only; writing one is flagged as an error.
	wire read_only = (sel == PWMUSC_SEL_ADUTY) || (sel == PWMUSC_SEL_APER) || (sel == PWMUSC_SEL_AOVR);
	wire bad_acc   = (sel == PWMUSC_SEL_NONE) || (PWRITE && read_only);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] widen(input logic [VAL_W-1:0] v);
		widen = {16'h0000, v};
	endfunction

	logic [DATA_W-1:0] read_word;

	// Reserved bits of every register read as zero.
	always_comb begin
		read_word = READ_ZERO;
		case (sel)
			PWMUSC_SEL_CTRL: begin
				read_word[POST_LSB +: POST_W] = event_trigger_postscale_select;
				read_word[BIT_IMM_UPDATE]     = immediate_update;
				read_word[BIT_OVR_SYNC]       = override_time_base_sync;
				read_word[BIT_XFER_DIS]       = buffer_transfer_disable;
			end
			PWMUSC_SEL_DUTY:  read_word = widen(duty_cycle_register);
			PWMUSC_SEL_PER:   read_word = widen(period_buffer);
			PWMUSC_SEL_OVR:   read_word = widen(output_override_control);
			PWMUSC_SEL_ADUTY: read_word = widen(ACTIVE_DUTY);
			PWMUSC_SEL_APER:  read_word = widen(ACTIVE_PERIOD);
			PWMUSC_SEL_AOVR:  read_word = widen(ACTIVE_OVERRIDE);
			default:          read_word = READ_ZERO;
		endcase
	end

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// One wait state lets PREADY, PRDATA and PSLVERR all come from flops.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY  <= 1'b0;
			PRDATA  <= READ_ZERO;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= access && !PREADY;
			PRDATA  <= (access && !PREADY && !PWRITE) ? read_word : READ_ZERO;
			PSLVERR <= access && !PREADY && bad_acc;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	wire [VAL_W-1:0] wr_val = PWDATA[VAL_W-1:0];

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			event_trigger_postscale_select <= RST_POSTSCALE;
			immediate_update               <= 1'b0;
			override_time_base_sync        <= 1'b0;
			buffer_transfer_disable        <= 1'b0;
		end else if (wr_ctrl) begin
			event_trigger_postscale_select <= PWDATA[POST_LSB +: POST_W];
			immediate_update               <= PWDATA[BIT_IMM_UPDATE];
			override_time_base_sync        <= PWDATA[BIT_OVR_SYNC];
			buffer_transfer_disable        <= PWDATA[BIT_XFER_DIS];
		end
	end

	// Next buffer values, so that a write on the update-point edge is not missed.
	wire [VAL_W-1:0] next_duty   = wr_duty   ? wr_val : duty_cycle_register;
	wire [VAL_W-1:0] next_period = wr_period ? wr_val : period_buffer;
	wire [VAL_W-1:0] next_ovr    = wr_ovr    ? wr_val : output_override_control;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			duty_cycle_register     <= RST_VALUE;
			period_buffer           <= RST_VALUE;
			output_override_control <= RST_VALUE;
		end else begin
			duty_cycle_register     <= next_duty;
			period_buffer           <= next_period;
			output_override_control <= next_ovr;
		end
	end

	// ----------------------------------------------------------------
	// Transfers into the active values
	// ----------------------------------------------------------------
	// The disable bit blocks every buffer transfer, immediate ones included.
	wire xfer_ok     = !buffer_transfer_disable; // [RULE5]
	wire sync_load   = TIME_BASE_SYNC && xfer_ok; // [RULE2]
	wire duty_now    = wr_duty && immediate_update && xfer_ok; // [RULE1]
	wire load_duty   = sync_load || duty_now;
	wire load_period = sync_load;
	// Override changes are not buffer transfers, so the disable bit does not hold them.
	wire load_ovr    = override_time_base_sync ? TIME_BASE_SYNC : 1'b1; // [RULE3] [RULE4]

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ACTIVE_DUTY     <= RST_VALUE;
			ACTIVE_PERIOD   <= RST_VALUE;
			ACTIVE_OVERRIDE <= RST_VALUE;
		end else begin
			if (load_duty) begin
				ACTIVE_DUTY <= next_duty; // [RULE1] [RULE2]
			end
			if (load_period) begin
				ACTIVE_PERIOD <= next_period; // [RULE5]
			end
			if (load_ovr) begin
				ACTIVE_OVERRIDE <= next_ovr; // [RULE3] [RULE4]
			end
		end
	end

	// ----------------------------------------------------------------
	// Special event postscaler
	// ----------------------------------------------------------------
	pwmusc_postscale pwmusc_postscale_inst (
		.clk      (CORE_CLK),
		.rstn     (RSTN),
		.event_in (SPECIAL_EVENT),
		.select   (event_trigger_postscale_select),
		.trigger  (SPECIAL_TRIGGER)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	immediate_duty_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // [RULE1]
		wr_duty && immediate_update && !buffer_transfer_disable |=> ACTIVE_DUTY == $past(PWDATA[15:0]))
		else $error("Immediate duty write did not reach the active value.");

	deferred_duty_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // [RULE2]
		!immediate_update && !TIME_BASE_SYNC |=> $stable(ACTIVE_DUTY))
		else $error("Active duty changed away from the update point.");

	sync_load_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // [RULE2]
		TIME_BASE_SYNC && !buffer_transfer_disable && !wr_duty && !wr_period
		|=> ACTIVE_DUTY == $past(duty_cycle_register) && ACTIVE_PERIOD == $past(period_buffer))
		else $error("Update point did not load the buffers.");

	override_sync_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // [RULE3]
		override_time_base_sync && !TIME_BASE_SYNC |=> $stable(ACTIVE_OVERRIDE))
		else $error("Synchronised override changed off the time base.");

	override_now_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // [RULE4]
		wr_ovr && !override_time_base_sync |=> ACTIVE_OVERRIDE == $past(PWDATA[15:0]))
		else $error("Override write did not apply on the next clock.");

	transfer_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // [RULE5]
		buffer_transfer_disable |=> $stable(ACTIVE_DUTY) && $stable(ACTIVE_PERIOD))
		else $error("Buffer transfer happened while disabled.");

	apb_ready_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY)
		else $error("Slave answer not one wait state after setup.");

endmodule

// file: verilog/pwmusc_pkg.sv
// Purpose: Shared constants for the PWM update and synchronisation control block.
// Assumes: One 40 MHz core clock, APB register access with 32-bit data.
// Notes:   Register word offsets are byte addresses; unused bits read as zero.
//
// Summary of operation
// [RULE1] With immediate update set, a duty write reaches the active duty value at the same edge.
// [RULE2] With immediate update clear, new duty values wait for the time-base update point.
// [RULE3] With override sync set, override changes take effect only at the time-base update point.
// [RULE4] With override sync clear, a written override setting takes effect at the next clock edge.
// [RULE5] With buffer transfer disable set, no duty or period transfer into the active values happens.
// [RULE6] Special event pulses are divided by the postscale select plus one to make the trigger output.
package pwmusc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          VAL_W           = 16;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
	localparam logic [7:0]  ADDR_DUTY       = 8'h04;
	localparam logic [7:0]  ADDR_PERIOD     = 8'h08;
	localparam logic [7:0]  ADDR_OVERRIDE   = 8'h0C;
	localparam logic [7:0]  ADDR_ACT_DUTY   = 8'h10;
	localparam logic [7:0]  ADDR_ACT_PERIOD = 8'h14;
	localparam logic [7:0]  ADDR_ACT_OVR    = 8'h18;

	// ----------------------------------------------------------------
	// Control register fields and reset values
	// ----------------------------------------------------------------
	localparam int          BIT_XFER_DIS    = 0;
	localparam int          BIT_OVR_SYNC    = 1;
	localparam int          BIT_IMM_UPDATE  = 2;
	localparam int          POST_LSB        = 8;
	localparam int          POST_W          = 4;
	localparam logic [3:0]  RST_POSTSCALE   = 4'h0;
	localparam logic [15:0] RST_VALUE       = 16'h0000;
	localparam logic [31:0] READ_ZERO       = 32'h00000000;

	// Decoded register select.
	typedef enum logic [2:0] {
		PWMUSC_SEL_NONE, PWMUSC_SEL_CTRL, PWMUSC_SEL_DUTY, PWMUSC_SEL_PER,
		PWMUSC_SEL_OVR, PWMUSC_SEL_ADUTY, PWMUSC_SEL_APER, PWMUSC_SEL_AOVR
	} pwmusc_sel_t;

endpackage

// file: verilog/pwmusc_postscale.sv
// Purpose: Postscaler for the special event trigger.
// Assumes: Event input is a one-cycle pulse synchronous to the clock.
// Notes:   Trigger is a one-cycle pulse from a flip-flop.
`timescale 1ns/1ps
module pwmusc_postscale
	import pwmusc_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rstn,
	// Event in, select, trigger out.
	input  wire logic              event_in,
	input  wire logic [pwmusc_pkg::POST_W-1:0] select,
	output logic                   trigger
);
	import pwmusc_pkg::*;

	logic [POST_W-1:0] count;
	wire               wrap = event_in && (count >= select);

	// Counting with >= keeps the divider sane when software lowers the select mid-count.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count   <= RST_POSTSCALE;
			trigger <= 1'b0;
		end else begin
			trigger <= wrap; // [RULE6]
			if (wrap) begin
				count <= RST_POSTSCALE;
			end else if (event_in) begin
				count <= count + 4'h1; // [RULE6]
			end
		end
	end

	post_fire_a: assert property (@(posedge clk) disable iff (!rstn) wrap |=> trigger) // [RULE6]
		else $error("Postscaler missed its trigger.");
	post_only_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
		trigger |-> $past(event_in) && ($past(count) >= $past(select)))
		else $error("Trigger without a completed event count.");

endmodule

// file: verif/pwmusc_top_tb.sv
// Purpose: Self-checking bench for the PWM update and synchronisation control block.
// Assumes: APB master with no fixed wait count; time-base and event inputs are one-cycle pulses.
// Notes:   Register checks run at the falling edge, after the rising edge's updates have landed; trigger counts are checked at a rising edge.
`timescale 1ns/1ps
module pwmusc_top_tb;
	import pwmusc_pkg::*;

	// ----------------------------------------------------------------
	// Signals and counters
	// ----------------------------------------------------------------
	logic                core_clk;
	logic                rstn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [DATA_W-1:0]   pwdata;
	logic [DATA_W-1:0]   prdata;
	logic                pready;
	logic                pslverr;
	logic                tb_sync;
	logic                sp_event;
	logic                sp_trig;
	logic [VAL_W-1:0]    act_duty;
	logic [VAL_W-1:0]    act_per;
	logic [VAL_W-1:0]    act_ovr;
	logic [DATA_W-1:0]   rd;
	logic                er;
	int                  n_mismatch = 0;
	int                  cmp_count = 0;
	int                  trig_cnt = 0;
	int                  trig_base;
	logic [3:0]          codes [4] = '{4'h0, 4'h1, 4'h3, 4'hF};

	pwmusc_top pwmusc_top_inst (
		.CORE_CLK(core_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TIME_BASE_SYNC(tb_sync), .SPECIAL_EVENT(sp_event), .SPECIAL_TRIGGER(sp_trig),
		.ACTIVE_DUTY(act_duty), .ACTIVE_PERIOD(act_per), .ACTIVE_OVERRIDE(act_ovr));

	// Clock at 40 MHz.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Trigger pulses are one cycle wide, so counting high samples counts pulses.
	always @(posedge core_clk) begin
		if (sp_trig === 1'b1) trig_cnt <= trig_cnt + 1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_mismatch++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(negedge core_clk);
	endtask

	// A one-cycle pulse on the time-base update point.
	task automatic sync_pulse();
		@(posedge core_clk) tb_sync <= 1'b1;
		@(posedge core_clk) tb_sync <= 1'b0;
		@(negedge core_clk);
	endtask

	// A one-cycle special event with a quiet cycle after it.
	task automatic event_pulse();
		@(posedge core_clk) sp_event <= 1'b1;
		@(posedge core_clk) sp_event <= 1'b0;
	endtask

	// Watchdog; the full sequence needs well under a thousand cycles.
	initial begin
		#(25 * 20000);
		n_mismatch++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; tb_sync = 1'b0; sp_event = 1'b0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		check(32'(act_duty), 32'h0);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		check(rd, 32'h0);
		check({31'h0, er}, 32'h0);
		// Only the implemented control fields read back.
		apb(1'b1, ADDR_CONTROL, 32'hFFFFFFFF);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		check(rd, 32'h00000F07);
		// Refusals: unmapped, misaligned and read-only places.
		apb(1'b0, 8'h1C, 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0);
		apb(1'b0, 8'h02, 32'h0);
		check({31'h0, er}, 32'h1);
		apb(1'b1, ADDR_ACT_DUTY, 32'h0000BEEF);
		check({31'h0, er}, 32'h1);
		// Immediate update: the duty write shows up right after its completion edge.
		apb(1'b1, ADDR_CONTROL, 32'h00000004);
		apb(1'b1, ADDR_DUTY, 32'h00001234);
		check(32'(act_duty), 32'h1234);
		apb(1'b0, ADDR_ACT_DUTY, 32'h0);
		check(rd, 32'h00001234);
		// Synchronised update: duty and period wait for the time-base point.
		apb(1'b1, ADDR_CONTROL, 32'h00000000);
		apb(1'b1, ADDR_DUTY, 32'h00005555);
		apb(1'b1, ADDR_PERIOD, 32'h00000100);
		check(32'(act_duty), 32'h1234);
		check(32'(act_per), 32'h0);
		sync_pulse();
		check(32'(act_duty), 32'h5555);
		check(32'(act_per), 32'h0100);
		// Transfer disable blocks immediate and synchronised loads alike.
		apb(1'b1, ADDR_CONTROL, 32'h00000005);
		apb(1'b1, ADDR_DUTY, 32'h00007777);
		apb(1'b1, ADDR_PERIOD, 32'h00000200);
		check(32'(act_duty), 32'h5555);
		sync_pulse();
		check(32'(act_duty), 32'h5555);
		check(32'(act_per), 32'h0100);
		// Unsynchronised override applies next cycle, even with transfers disabled.
		apb(1'b1, ADDR_OVERRIDE, 32'h000000AA);
		check(32'(act_ovr), 32'h00AA);
		// Synchronised override waits for the time-base point.
		apb(1'b1, ADDR_CONTROL, 32'h00000002);
		apb(1'b1, ADDR_OVERRIDE, 32'h00000055);
		repeat (3) @(negedge core_clk);
		check(32'(act_ovr), 32'h00AA);
		sync_pulse();
		check(32'(act_ovr), 32'h0055);
		check(32'(act_duty), 32'h7777);
		check(32'(act_per), 32'h0200);
		// Postscaler: one trigger per select plus one events, at boundary codes.
		foreach (codes[i]) begin
			apb(1'b1, ADDR_CONTROL, 32'(codes[i]) << POST_LSB);
			for (int k = 1; k <= 2; k++) begin
				trig_base = trig_cnt;
				repeat (int'(codes[i])) event_pulse();
				repeat (2) @(posedge core_clk);
				check(32'(trig_cnt - trig_base), 32'h0);
				event_pulse();
				repeat (2) @(posedge core_clk);
				check(32'(trig_cnt - trig_base), 32'h1);
			end
		end
		summarize();
	end
endmodule
